// file: hdl/cbm_pkg.sv
package cbm_pkg;
    // buffer geometry
    localparam int RX_STAGES = 5;
    localparam int TX_BUFS = 3;
    localparam int RX_BODY_BYTES = 13;
    localparam int TX_BODY_BYTES = 14;
    localparam int ID_REGS = 8;
    localparam int TIMER_W = 16;
    localparam logic [3:0] STAMP_HI_OFS = 4'hE;
    localparam logic [3:0] STAMP_LO_OFS = 4'hF;
    // values after reset
    localparam logic [7:0] ID_RESET = 8'h00;
    localparam logic [2:0] TX_EMPTY_RESET = 3'h7;
    localparam logic [7:0] TX_SEL_RESET = 8'h00;
    localparam logic [15:0] STAMP_RESET = 16'h0000;
    // bit time of the stamp timer
    localparam int CLK_PERIOD_NS = 8;
    localparam int BIT_TIME_NS = 2000;
    localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {
        CBM_RUN = 1'b0,
        CBM_SLEEP = 1'b1
    } cbm_pwr_e;

    typedef struct packed {
        logic [RX_BODY_BYTES-1:0][7:0] body;
        logic [7:0] pad;
        logic [TIMER_W-1:0] stamp;
    } cbm_rx_buf_s;

    typedef struct packed {
        logic [TX_BODY_BYTES-1:0][7:0] body;
        logic [TIMER_W-1:0] stamp;
    } cbm_tx_buf_s;

    typedef struct packed {
        logic [ID_REGS-1:0][7:0] accept;
        logic [ID_REGS-1:0][7:0] mask;
    } cbm_id_filter_s;
endpackage : cbm_pkg

// file: hdl/cbm_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module cbm_fifo
    import cbm_pkg::*;
#(
    parameter int WIDTH = 128,
    parameter int DEPTH = RX_STAGES
)(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // filling side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // draining side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    assign in_ready_out = (count_r != FULL_CNT);
    assign out_valid_out = (count_r != '0);
    assign out_data_out = mem_r[rd_ptr_r];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_sys_in)
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
            if (push && !pop)
                count_r <= count_r + 1'b1;
            else if (pop && !push)
                count_r <= count_r - 1'b1;
        end
    end

    // R6: five stages
    fifo_bound_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        count_r <= FULL_CNT) else $error("fifo count past depth"); // R6
    fifo_fill_c: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        !in_ready_out);
endmodule : cbm_fifo
`default_nettype wire

// file: hdl/cbm_stamp_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cbm_stamp_timer
    import cbm_pkg::*;
#(
    parameter int CYCLES = BIT_CYCLES
)(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // control
    input wire logic clear_in,
    input wire logic enable_in,
    // count
    output logic [TIMER_W-1:0] count_out
);
    localparam logic [15:0] DIV_LAST = 16'(CYCLES - 1);
    logic [15:0] div_r;
    logic tick_r;

    // bit-rate enable pulse
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            div_r <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= (div_r == DIV_LAST);
            div_r <= (div_r == DIV_LAST) ? '0 : div_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            count_out <= STAMP_RESET;
        // R19: zero in init
        else if (clear_in)
            count_out <= STAMP_RESET;
        // R17: one step per bit
        else if (enable_in && tick_r)
            count_out <= count_out + 16'h0001;
    end

    timer_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        clear_in |=> count_out == 16'h0000) else $error("timer not held"); // R19
    timer_step_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !clear_in && !(enable_in && tick_r) |=> $stable(count_out))
        else $error("timer moved off tick"); // R17
endmodule : cbm_stamp_timer
`default_nettype wire

// file: hdl/cbm_core.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// R1: asleep with wake enable and request, bus activity wakes the block
// R2: wake request toward the cpu only when wake irq enable is set
// R3: listen-only still receives frames but drives recessive only
// R4: listen-only never starts a transmission
// R5: listen-only dominant bits loop back internally, bus stays recessive
// R6: received messages queue in a five-stage fifo
// R7: receive buffer is 16 bytes: 13 message bytes, stamp on top
// R8: timer enabled, each reception gets a 16-bit stamp
// R9: three transmit buffers
// R10: only the selected transmit buffer appears in the cpu window
// R11: select write keeps only the lowest set bit
// R12: select read returns the lowest set bit only
// R13: software writes the empty flags into the select register
// R14: transmit buffer is 16 bytes: 14 message bytes, stamp on top
// R15: timer enabled, each sent buffer gets a 16-bit stamp
// R16: acceptance and mask registers reset to zero
// R17: stamp timer is internal, free running, one step per bit
// R18: stamp is caught at the ack delimiter sample point
// R19: timer held at zero during init mode
// R20: wake enable low, bus traffic is ignored while asleep
// R21: select write of zero selects nothing and reads zero
module cbm_core
    import cbm_pkg::*;
#(
    parameter int STAMP_CYCLES = BIT_CYCLES
)(
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // mode
    input wire logic init_mode_in,
    input wire logic listen_only_in,
    input wire logic timer_enable_in,
    // power
    input wire logic sleep_request_in,
    input wire logic wake_on_bus_enable_in,
    input wire logic wake_irq_enable_in,
    output logic sleep_acknowledge_out,
    output logic wake_cpu_out,
    // bus pins
    input wire logic can_rx_in,
    output logic can_tx_out,
    // protocol engine
    input wire logic mac_tx_bit_in,
    output logic mac_rx_bit_out,
    input wire logic mac_idle_in,
    input wire logic ack_delim_in,
    input wire logic rx_msg_valid_in,
    input wire logic [RX_BODY_BYTES-1:0][7:0] rx_msg_in,
    output logic rx_msg_ready_out,
    output logic tx_start_out,
    output logic [1:0] tx_index_out,
    output logic [TX_BODY_BYTES-1:0][7:0] tx_frame_out,
    input wire logic tx_done_in,
    input wire logic tx_abort_in,
    // cpu receive window
    output cbm_rx_buf_s rx_head_out,
    output logic rx_head_valid_out,
    input wire logic rx_release_in,
    // cpu transmit side
    input wire logic tx_select_wr_in,
    input wire logic [7:0] tx_select_wdata_in,
    output logic [7:0] tx_select_out,
    input wire logic [TX_BUFS-1:0] tx_send_in,
    output logic [TX_BUFS-1:0] tx_empty_flags_out,
    input wire logic tx_win_wr_in,
    input wire logic [3:0] tx_win_addr_in,
    input wire logic [7:0] tx_win_wdata_in,
    output logic [7:0] tx_win_rdata_out,
    // identifier filter
    input wire logic id_wr_in,
    input wire logic id_mask_sel_in,
    input wire logic [2:0] id_addr_in,
    input wire logic [7:0] id_wdata_in,
    output cbm_id_filter_s id_filter_out
);
    cbm_pwr_e pwr_r;
    logic rx_meta_r;
    logic rx_sync_r;
    logic wake_block_r;
    logic wake_evt;
    logic [TIMER_W-1:0] timer_count;
    logic [TIMER_W-1:0] stamp_r;
    cbm_tx_buf_s tx_buf_r [TX_BUFS];
    logic tx_busy_r;
    logic [1:0] sel_idx;
    logic sel_any;
    logic [1:0] next_idx;
    logic next_any;
    logic [2:0] sel_low;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_take;
    cbm_rx_buf_s fifo_in;
    cbm_rx_buf_s fifo_out;

    // bus pin synchroniser
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end
        else
        begin
            rx_meta_r <= can_rx_in;
            rx_sync_r <= rx_meta_r;
        end
    end

    // R1: dominant level wakes
    assign wake_evt = (pwr_r == CBM_SLEEP) && sleep_request_in &&
        wake_on_bus_enable_in && !rx_sync_r;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            pwr_r <= CBM_RUN;
        else
        begin
            unique case (pwr_r)
                CBM_RUN:
                begin
                    if (sleep_request_in && !wake_block_r && mac_idle_in &&
                        !tx_busy_r && !init_mode_in)
                        pwr_r <= CBM_SLEEP;
                end
                CBM_SLEEP:
                begin
                    // R20: no wake without enable
                    if (!sleep_request_in || wake_evt)
                        pwr_r <= CBM_RUN;
                end
            endcase
        end
    end

    // after a wake, sleep again only on a fresh request
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            wake_block_r <= 1'b0;
        else if (wake_evt)
            wake_block_r <= 1'b1;
        else if (!sleep_request_in)
            wake_block_r <= 1'b0;
    end

    assign sleep_acknowledge_out = (pwr_r == CBM_SLEEP);

    // R2: cpu wake gated
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            wake_cpu_out <= 1'b0;
        else
            wake_cpu_out <= wake_evt && wake_irq_enable_in;
    end

    // R3: recessive in listen
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            can_tx_out <= 1'b1;
        else if (listen_only_in || pwr_r == CBM_SLEEP)
            can_tx_out <= 1'b1;
        else
            can_tx_out <= mac_tx_bit_in;
    end

    // R5: dominant loop back
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            mac_rx_bit_out <= 1'b1;
        else
            mac_rx_bit_out <= rx_sync_r &
                (listen_only_in ? mac_tx_bit_in : 1'b1);
    end

    cbm_stamp_timer #(
        .CYCLES(STAMP_CYCLES)
    ) u_timer (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .clear_in(init_mode_in),
        .enable_in(timer_enable_in),
        .count_out(timer_count)
    );

    // R18: catch at ack delimiter
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            stamp_r <= STAMP_RESET;
        else if (ack_delim_in)
            stamp_r <= timer_count;
    end

    // R7: 13 bytes plus stamp
    always_comb
    begin
        fifo_in.body = rx_msg_in;
        fifo_in.pad = 8'h00;
        // R8: stamp on reception
        fifo_in.stamp = timer_enable_in ? stamp_r : STAMP_RESET;
    end

    // R3: receive in listen too
    cbm_fifo #(
        .WIDTH($bits(cbm_rx_buf_s)),
        .DEPTH(RX_STAGES)
    ) u_rx_fifo (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .in_valid_in(rx_msg_valid_in),
        .in_ready_out(fifo_ready),
        .in_data_in(fifo_in),
        .out_valid_out(fifo_valid),
        .out_ready_in(fifo_take),
        .out_data_out(fifo_out)
    );

    assign fifo_take = !rx_head_valid_out || rx_release_in;

    // foreground receive buffer seen by the cpu
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            rx_head_valid_out <= 1'b0;
            rx_head_out <= '0;
            rx_msg_ready_out <= 1'b0;
        end
        else
        begin
            rx_msg_ready_out <= fifo_ready;
            if (fifo_take)
            begin
                rx_head_valid_out <= fifo_valid;
                if (fifo_valid)
                    rx_head_out <= fifo_out;
            end
        end
    end

    // R11 R21: lowest set bit
    assign sel_low = tx_select_wdata_in[2:0] &
        (~tx_select_wdata_in[2:0] + 3'h1);

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || init_mode_in)
            tx_select_out <= TX_SEL_RESET;
        // R12: read back one bit
        else if (tx_select_wr_in)
            tx_select_out <= {5'h00, sel_low};
    end

    // R10: decode the window
    always_comb
    begin
        sel_idx = 2'd0;
        sel_any = 1'b0;
        next_idx = 2'd0;
        next_any = 1'b0;
        for (int i = TX_BUFS - 1; i >= 0; i--)
        begin
            if (tx_select_out[i])
            begin
                sel_idx = 2'(i);
                sel_any = 1'b1;
            end
            if (!tx_empty_flags_out[i])
            begin
                next_idx = 2'(i);
                next_any = 1'b1;
            end
        end
    end

    // R9: three buffers
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < TX_BUFS; i++)
                tx_buf_r[i] <= '0;
        end
        else
        begin
            // R14: 14 bytes, stamp on top
            if (tx_win_wr_in && sel_any && tx_win_addr_in < STAMP_HI_OFS)
                tx_buf_r[sel_idx].body[tx_win_addr_in] <= tx_win_wdata_in;
            // R15: stamp on success
            if (tx_done_in && tx_busy_r && timer_enable_in)
                tx_buf_r[tx_index_out].stamp <= stamp_r;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || !sel_any)
            tx_win_rdata_out <= 8'h00;
        else if (tx_win_addr_in == STAMP_HI_OFS)
            tx_win_rdata_out <= tx_buf_r[sel_idx].stamp[15:8];
        else if (tx_win_addr_in == STAMP_LO_OFS)
            tx_win_rdata_out <= tx_buf_r[sel_idx].stamp[7:0];
        else
            tx_win_rdata_out <= tx_buf_r[sel_idx].body[tx_win_addr_in];
    end

    // empty flags: completion sets, cpu send clears, set wins
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || init_mode_in)
            tx_empty_flags_out <= TX_EMPTY_RESET;
        else
        begin
            for (int i = 0; i < TX_BUFS; i++)
            begin
                if (tx_done_in && tx_busy_r && tx_index_out == 2'(i))
                    tx_empty_flags_out[i] <= 1'b1;
                else if (tx_send_in[i])
                    tx_empty_flags_out[i] <= 1'b0;
            end
        end
    end

    // transmit launcher
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in || init_mode_in)
        begin
            tx_busy_r <= 1'b0;
            tx_start_out <= 1'b0;
            tx_index_out <= 2'd0;
            tx_frame_out <= '0;
        end
        else
        begin
            tx_start_out <= 1'b0;
            if (tx_busy_r && (tx_done_in || tx_abort_in))
                tx_busy_r <= 1'b0;
            // R4: no start in listen
            else if (!tx_busy_r && next_any && !listen_only_in &&
                     mac_idle_in && pwr_r == CBM_RUN)
            begin
                tx_busy_r <= 1'b1;
                tx_start_out <= 1'b1;
                tx_index_out <= next_idx;
                tx_frame_out <= tx_buf_r[next_idx].body;
            end
        end
    end

    // R16: filter reset
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            id_filter_out <= {2 * ID_REGS{ID_RESET}};
        else if (id_wr_in && init_mode_in)
        begin
            if (id_mask_sel_in)
                id_filter_out.mask[id_addr_in] <= id_wdata_in;
            else
                id_filter_out.accept[id_addr_in] <= id_wdata_in;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    wake_bus_a: assert property (wake_evt |=> pwr_r == CBM_RUN) // R1
        else $error("bus activity did not wake");
    stay_asleep_a: assert property (pwr_r == CBM_SLEEP && // R20
        !wake_on_bus_enable_in && sleep_request_in |=> pwr_r == CBM_SLEEP)
        else $error("woke with wake disabled");
    wake_irq_a: assert property (wake_cpu_out |-> // R2
        $past(wake_irq_enable_in) && $past(pwr_r == CBM_SLEEP))
        else $error("cpu wake without enable");
    listen_quiet_a: assert property (listen_only_in |=> can_tx_out) // R3
        else $error("dominant driven in listen");
    listen_no_start_a: assert property (listen_only_in |=> // R4
        !tx_start_out) else $error("start in listen");
    loop_back_a: assert property (listen_only_in && !mac_tx_bit_in // R5
        |=> !mac_rx_bit_out && can_tx_out) else $error("loop back lost");
    sel_onehot_a: assert property ($onehot0(tx_select_out) && // R12
        tx_select_out[7:3] == 5'h00) else $error("select not one bit");
    sel_lowest_a: assert property (tx_select_wr_in && !init_mode_in && // R11
        tx_select_wdata_in[0] |=> tx_select_out == 8'h01)
        else $error("lowest bit not chosen");
    sel_zero_a: assert property (tx_select_wr_in && !init_mode_in && // R21
        tx_select_wdata_in[2:0] == 3'h0 |=> tx_select_out == 8'h00)
        else $error("empty select not zero");
    tx_stamp_a: assert property (tx_done_in && tx_busy_r && // R15
        timer_enable_in && !init_mode_in |=>
        tx_buf_r[$past(tx_index_out)].stamp == $past(stamp_r))
        else $error("tx stamp missing");
    id_reset_a: assert property ($past(rst_in) |-> // R16
        id_filter_out == '0) else $error("filter not cleared");

    wake_c: cover property (pwr_r == CBM_SLEEP ##1 wake_cpu_out);
    tx_done_c: cover property (tx_start_out ##[1:300] tx_done_in);
    rx_listen_c: cover property (listen_only_in && rx_msg_valid_in &&
        rx_msg_ready_out);
endmodule : cbm_core
`default_nettype wire

// file: verif/cbm_bus_node.sv
`timescale 1ns/1ns
`default_nettype none
module cbm_bus_node (
    // clock
    input wire logic clk_sys_in,
    // command from the bench
    input wire logic dom_in,
    // bus
    input wire logic dev_tx_in,
    output logic bus_out
);
    logic dom_r = 1'b0;
    // other node drives dominant only while commanded, idle otherwise
    always_ff @(posedge clk_sys_in)
    begin
        dom_r <= dom_in;
    end
    // wired-and bus, recessive high
    assign bus_out = dev_tx_in & ~dom_r;
endmodule : cbm_bus_node
`default_nettype wire

// file: verif/tb_cbm_core.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
    begin \
        samples_checked++; \
        if ((gt) !== (ex)) \
        begin \
            err_count++; \
            $display("Error %s expected %0h seen %0h", nm, ex, gt); \
        end \
    end
module tb_cbm_core;
    import cbm_pkg::*;
    localparam int SC = 4;
    typedef struct {
        cbm_rx_buf_s w;
        int c;
    } cbm_exp_s;
    logic clk_sys_in, rst_in, init_mode_in, listen_only_in, timer_enable_in;
    logic sleep_request_in, wake_on_bus_enable_in, wake_irq_enable_in;
    logic sleep_acknowledge_out, wake_cpu_out, can_rx_in, can_tx_out;
    logic mac_tx_bit_in, mac_rx_bit_out, mac_idle_in, ack_delim_in;
    logic rx_msg_valid_in, rx_msg_ready_out, tx_start_out, tx_done_in;
    logic [RX_BODY_BYTES-1:0][7:0] rx_msg_in;
    logic [1:0] tx_index_out;
    logic [TX_BODY_BYTES-1:0][7:0] tx_frame_out;
    logic tx_abort_in, rx_head_valid_out, rx_release_in, tx_select_wr_in;
    cbm_rx_buf_s rx_head_out;
    logic [7:0] tx_select_wdata_in, tx_select_out, tx_win_wdata_in;
    logic [7:0] tx_win_rdata_out, id_wdata_in;
    logic [TX_BUFS-1:0] tx_send_in, tx_empty_flags_out;
    logic tx_win_wr_in, id_wr_in, id_mask_sel_in, dom;
    logic [3:0] tx_win_addr_in;
    logic [2:0] id_addr_in;
    cbm_id_filter_s id_filter_out;
    int err_count = 0, samples_checked = 0;
    int cyc = 0, starts = 0, wakes = 0;
    int txc;
    bit drain = 0;
    cbm_exp_s expq[$];

    cbm_core #(.STAMP_CYCLES(SC)) DUT (
        .clk_sys_in, .rst_in, .init_mode_in, .listen_only_in,
        .timer_enable_in, .sleep_request_in, .wake_on_bus_enable_in,
        .wake_irq_enable_in, .sleep_acknowledge_out, .wake_cpu_out,
        .can_rx_in, .can_tx_out, .mac_tx_bit_in, .mac_rx_bit_out,
        .mac_idle_in, .ack_delim_in, .rx_msg_valid_in, .rx_msg_in,
        .rx_msg_ready_out, .tx_start_out, .tx_index_out, .tx_frame_out,
        .tx_done_in, .tx_abort_in, .rx_head_out, .rx_head_valid_out,
        .rx_release_in, .tx_select_wr_in, .tx_select_wdata_in,
        .tx_select_out, .tx_send_in, .tx_empty_flags_out, .tx_win_wr_in,
        .tx_win_addr_in, .tx_win_wdata_in, .tx_win_rdata_out, .id_wr_in,
        .id_mask_sel_in, .id_addr_in, .id_wdata_in, .id_filter_out
    );
    cbm_bus_node node (.clk_sys_in, .dom_in(dom), .dev_tx_in(can_tx_out),
        .bus_out(can_rx_in));

    initial
    begin
        clk_sys_in = 0;
        forever #4 clk_sys_in = ~clk_sys_in;
    end

    // event counters and bit-time reference
    always @(posedge clk_sys_in)
    begin
        cyc <= init_mode_in ? 0 : cyc + 1;
        if (tx_start_out === 1'b1) starts <= starts + 1;
        if (wake_cpu_out === 1'b1) wakes <= wakes + 1;
    end

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask : step

    task automatic waitv(ref logic s, input logic v);
        int i;
        for (i = 0; i < 200 && s !== v; i++) step(1);
        if (s !== v)
        begin
            `CHK("wait", v, s)
            tally_and_finish();
        end
    endtask : waitv

    task automatic wait_start(input int s0);
        int i;
        for (i = 0; i < 200 && starts == s0; i++) step(1);
        `CHK("tx start", 1'b1, starts != s0)
        if (starts == s0) tally_and_finish();
    endtask : wait_start

    function automatic logic near(input logic [15:0] g, input int c);
        int e;
        e = c / SC;
        return !$isunknown(g) && (int'(g) >= e - 3) && (int'(g) <= e + 2);
    endfunction : near

    task automatic selw(input logic [7:0] d);
        tx_select_wdata_in = d;
        tx_select_wr_in = 1;
        step(1);
        tx_select_wr_in = 0;
        step(1);
    endtask : selw

    task automatic rd(input logic [3:0] a);
        tx_win_addr_in = a;
        step(1);
    endtask : rd

    task automatic ww(input logic [3:0] a, input logic [7:0] d);
        tx_win_addr_in = a;
        tx_win_wdata_in = d;
        tx_win_wr_in = 1;
        step(1);
        tx_win_wr_in = 0;
    endtask : ww

    task automatic idw(input logic m, input logic [2:0] a,
        input logic [7:0] d);
        id_mask_sel_in = m;
        id_addr_in = a;
        id_wdata_in = d;
        id_wr_in = 1;
        step(1);
        id_wr_in = 0;
        step(1);
    endtask : idw

    task automatic pulse_ack;
        ack_delim_in = 1;
        txc = cyc;
        step(1);
        ack_delim_in = 0;
        step(1);
    endtask : pulse_ack

    task automatic sendrx(input bit keep);
        cbm_exp_s x;
        pulse_ack();
        x.c = txc;
        if (keep) waitv(rx_msg_ready_out, 1'b1);
        for (int b = 0; b < RX_BODY_BYTES; b++) rx_msg_in[b] = 8'($urandom);
        x.w = {rx_msg_in, 8'h00, 16'h0000};
        rx_msg_valid_in = 1;
        step(1);
        rx_msg_valid_in = 0;
        if (keep) expq.push_back(x);
    endtask : sendrx

    task automatic txdone;
        pulse_ack();
        tx_done_in = 1;
        step(1);
        tx_done_in = 0;
        step(1);
    endtask : txdone

    // receive side: compare each head against the oldest note
    initial
    begin
        cbm_exp_s x;
        rx_release_in = 0;
        forever
        begin
            step(1);
            if (drain && rx_head_valid_out === 1'b1)
            begin
                `CHK("rx queue", 1'b1, expq.size() != 0)
                x = expq.size() != 0 ? expq.pop_front() : x;
                `CHK("rx body", x.w.body, rx_head_out.body)
                `CHK("rx pad", 8'h00, rx_head_out.pad)
                `CHK("rx stamp", 1'b1, near(rx_head_out.stamp, x.c))
                rx_release_in = 1;
                step(1);
                rx_release_in = 0;
                step(3);
            end
        end
    end

    initial
    begin
        logic [7:0] d, e, v1, v2;
        {init_mode_in, rst_in, timer_enable_in, mac_tx_bit_in} = 4'hF;
        {listen_only_in, sleep_request_in, wake_on_bus_enable_in} = 3'h0;
        {wake_irq_enable_in, ack_delim_in, rx_msg_valid_in} = 3'h0;
        {tx_done_in, tx_abort_in, tx_select_wr_in, tx_win_wr_in} = 4'h0;
        {id_wr_in, id_mask_sel_in, dom, mac_idle_in} = 4'h1;
        rx_msg_in = '0;
        tx_select_wdata_in = 8'h00;
        tx_send_in = 3'h0;
        {tx_win_addr_in, tx_win_wdata_in} = 12'h000;
        {id_addr_in, id_wdata_in} = 11'h000;
        void'($urandom(77721));
        step(12);
        rst_in = 0;
        step(1);
        `CHK("id filter", '0, id_filter_out)
        `CHK("tx empty", TX_EMPTY_RESET, tx_empty_flags_out)
        v1 = 8'($urandom);
        v2 = 8'($urandom);
        idw(1'b0, 3'h2, v1);
        idw(1'b1, 3'h5, v2);
        init_mode_in = 0;
        idw(1'b0, 3'h2, ~v1);
        `CHK("id accept", v1, id_filter_out.accept[2])
        `CHK("id mask", v2, id_filter_out.mask[5])
        for (int i = 0; i < 12; i++)
        begin
            d = (i == 0) ? 8'h06 : (i == 1) ? 8'hF8 : 8'($urandom);
            e = d[0] ? 8'h01 : d[1] ? 8'h02 : d[2] ? 8'h04 : 8'h00;
            selw(d);
            `CHK("tx select", e, tx_select_out)
        end
        // free buffer chosen from the empty flags
        selw({5'h00, tx_empty_flags_out});
        `CHK("tx select", 8'h01, tx_select_out)
        selw(8'h04);
        ww(4'h3, 8'hA5);
        selw(8'h01);
        ww(4'h3, 8'h5A);
        rd(4'h3);
        `CHK("win byte", 8'h5A, tx_win_rdata_out)
        selw(8'h04);
        rd(4'h3);
        `CHK("win byte", 8'hA5, tx_win_rdata_out)
        selw(8'h00);
        rd(4'h3);
        `CHK("win none", 8'h00, tx_win_rdata_out)
        listen_only_in = 1;
        tx_send_in = 3'b101;
        step(1);
        tx_send_in = 3'h0;
        step(20);
        `CHK("starts", 0, starts)
        `CHK("tx empty", 3'b010, tx_empty_flags_out)
        listen_only_in = 0;
        wait_start(0);
        tx_abort_in = 1;
        step(1);
        tx_abort_in = 0;
        wait_start(1);
        `CHK("tx index", 2'h0, tx_index_out)
        `CHK("tx frame", 8'h5A, tx_frame_out[3])
        txdone();
        wait_start(2);
        `CHK("tx index", 2'h2, tx_index_out)
        `CHK("tx frame", 8'hA5, tx_frame_out[3])
        txdone();
        `CHK("tx empty", 3'h7, tx_empty_flags_out)
        selw(8'h04);
        rd(STAMP_HI_OFS);
        d = tx_win_rdata_out;
        rd(STAMP_LO_OFS);
        `CHK("tx stamp", 1'b1, near({d, tx_win_rdata_out}, txc))
        listen_only_in = 1;
        mac_tx_bit_in = 0;
        step(1);
        `CHK("bus pin", 1'b1, can_tx_out)
        `CHK("loopback", 1'b0, mac_rx_bit_out)
        listen_only_in = 0;
        step(4);
        `CHK("bus pin", 1'b0, can_rx_in)
        {mac_tx_bit_in, listen_only_in} = 2'h3;
        step(4);
        for (int i = 0; i < 7; i++) sendrx(i < 6);
        step(3);
        `CHK("rx ready", 1'b0, rx_msg_ready_out)
        drain = 1;
        for (int i = 0; i < 300 && expq.size() != 0; i++) step(1);
        step(6);
        `CHK("rx left", 0, expq.size())
        `CHK("rx head", 1'b0, rx_head_valid_out)
        wake_irq_enable_in = 1;
        sleep_request_in = 1;
        waitv(sleep_acknowledge_out, 1'b1);
        dom = 1;
        step(10);
        dom = 0;
        step(4);
        `CHK("asleep", 1'b1, sleep_acknowledge_out)
        wake_on_bus_enable_in = 1;
        dom = 1;
        waitv(sleep_acknowledge_out, 1'b0);
        dom = 0;
        step(2);
        `CHK("wakes", 1, wakes)
        sleep_request_in = 0;
        step(4);
        wake_irq_enable_in = 0;
        sleep_request_in = 1;
        waitv(sleep_acknowledge_out, 1'b1);
        dom = 1;
        waitv(sleep_acknowledge_out, 1'b0);
        dom = 0;
        step(4);
        `CHK("wakes", 1, wakes)
        tally_and_finish();
    end
endmodule : tb_cbm_core
`default_nettype wire
